// ===== rtl/ctd_map.vh
// Purpose: register map and field constants for the counter/timer dio block
// Assumes: ahb-lite byte addresses, one 32-bit word per register
// Notes:   printed offsets are not all word multiples, so they are indices
`ifndef CTD_MAP_VH
`define CTD_MAP_VH
`define CTD_IDX_LOAD0      6'h02
`define CTD_IDX_HOLD0      6'h04
`define CTD_IDX_CMD0       6'h06
`define CTD_IDX_LOAD1      6'h0a
`define CTD_IDX_HOLD1      6'h0c
`define CTD_IDX_CMD1       6'h0e
`define CTD_IDX_CMDSEL     6'h20
`define CTD_IDX_IRQEN      6'h22
`define CTD_IDX_IRQCLR     6'h24
`define CTD_IDX_IRQSTAT    6'h26
`define CTD_IDX_DIR        6'h2c
`define CTD_IDX_PA_FLAGS   6'h2e
`define CTD_IDX_PB_FLAGS   6'h30
`define CTD_IDX_PC_FLAGS   6'h32
`define CTD_IDX_FOUT0      6'h38
`define CTD_IDX_FOUT1      6'h3a
`define CTD_OP_DISARM      3'h0
`define CTD_OP_LOAD        3'h1
`define CTD_OP_DISARM_SAVE 3'h2
`define CTD_OP_ARM         3'h4
`define CTD_OP_LOAD_ARM    3'h5
`define CTD_OP_SAVE        3'h6
`define CTD_OP_RESET       3'h7
`define CTD_FOE_BIT        12
`define CTD_FS_HI          10
`define CTD_FS_LO          8
`define CTD_DV_HI          3
`define CTD_DV_LO          0
`define CTD_IRQEN_RST      5'h00
`define CTD_DIR_RST        4'hf
`define CTD_FREQ_OUTPUT_RST       16'h0000
`define CTD_SYS_HZ         20000000
`define CTD_TICK_HZ        1000
`define CTD_CYC_LAST       5'h13
`define CTD_DEC_LAST       4'h9
`endif

// ===== rtl/ctd_counter.v
// Purpose: one 16-bit down counter with arm state, hold and reload
// Assumes: count_edge is a one-cycle pulse per active source edge
// Notes:   single-shot: reload then disarm at terminal count
`timescale 1ns/1ps
`default_nettype none
`include "ctd_map.vh"
module ctd_counter (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        cmd_stb,
  input  wire [2:0]  opcode_field,
  input  wire [15:0] reload_word,
  input  wire        hold_wr,
  input  wire [15:0] hold_wdata,
  input  wire        count_edge,
  output reg  [15:0] count,
  output reg  [15:0] snapshot_word,
  output reg         armed,
  output reg         terminal_count
);
  wire tc_now = armed && count_edge && (count == 16'h0001);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count          <= 16'h0000;
      snapshot_word  <= 16'h0000;
      armed          <= 1'b0;
      terminal_count <= 1'b0;
    end else begin
      terminal_count <= tc_now;
      if (hold_wr) begin
        snapshot_word <= hold_wdata;
      end
      if (cmd_stb) begin
        case (opcode_field)
          `CTD_OP_DISARM: armed <= 1'b0;
          `CTD_OP_LOAD: count <= reload_word;
          `CTD_OP_DISARM_SAVE: begin
            armed         <= 1'b0;
            snapshot_word <= count;
          end
          `CTD_OP_ARM: armed <= 1'b1;
          `CTD_OP_LOAD_ARM: begin
            count <= reload_word;
            armed <= 1'b1;
          end
          `CTD_OP_SAVE: snapshot_word <= count;
          `CTD_OP_RESET: begin
            armed <= 1'b0;
            count <= 16'h0000;
          end
          default: armed <= armed;
        endcase
      end else if (tc_now) begin
        count <= reload_word;
        armed <= 1'b0;
      end else if (armed && count_edge) begin
        count <= count - 16'h0001;
      end
    end
  end
endmodule // ctd_counter
`default_nettype wire

// ===== rtl/ctd_freq_out.v
// Purpose: one programmable frequency output with source select and divider
// Assumes: source pulses are one-cycle enables in the hclk domain
// Notes:   output is a pulse train, one hclk wide per divided period
`timescale 1ns/1ps
`default_nettype none
`include "ctd_map.vh"
module ctd_freq_out (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire [15:0] ctrl,
  input  wire [7:0]  src_pulses,
  output reg         freq_output,
  output reg         freq_drive_en
);
  wire [2:0] freq_source_sel = ctrl[`CTD_FS_HI:`CTD_FS_LO];
  wire [3:0] divide_ratio    = ctrl[`CTD_DV_HI:`CTD_DV_LO];
  reg  [3:0] div_cnt;
  wire       src = src_pulses[freq_source_sel];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt       <= 4'h0;
      freq_output   <= 1'b0;
      freq_drive_en <= 1'b0;
    end else begin
      freq_drive_en <= ctrl[`CTD_FOE_BIT];
      freq_output   <= 1'b0;
      if (src) begin
        if (div_cnt >= divide_ratio) begin
          div_cnt     <= 4'h0;
          // pulse gated so a disabled pin stays quiet
          freq_output <= ctrl[`CTD_FOE_BIT];
        end else begin
          div_cnt <= div_cnt + 4'h1;
        end
      end
    end
  end
endmodule // ctd_freq_out
`default_nettype wire

// ===== rtl/ctd_top.v
// Purpose: counter/timer with digital input interrupts, ahb-lite registers
// Assumes: single word transfers, one slave on the bus
// Notes:   byte address = 4 x register index; zero wait states
// Overview of operation
// - each counter has a writable 16-bit hold register
// - reload value comes from the full 16-bit load register
// - three-bit opcode: 000 disarm, 100 arm, 111 reset
// - opcode 001 loads count from load register
// - opcode 010 disarms and saves count into hold
// - opcode 101 loads then arms in one command
// - opcode 110 saves count into hold, arm state kept
// - one command select bit per counter, 1 selects
// - per-counter interrupt enable bits in control register
// - three input group interrupt enable bits, A B C
// - per-counter interrupt status bit reads 1 when occurred
// - per-group input interrupt status bit reads 1 when occurred
// - any write to clear location clears pending interrupts
// - direction bits 0 to 3 for C lower, B, C upper, A; 1 input
// - read-only per-bit input interrupt flags for ports A, B, C
// - frequency outputs divide source by 1 to 16
// - three-bit source select among eight sources, 111 is 1 kHz
// - frequency output drives only while its enable is 1
// - counting happens only while armed
// - single shot reloads at terminal count then disarms
`timescale 1ns/1ps
`default_nettype none
`include "ctd_map.vh"
module ctd_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire [1:0]  clk_in,
  input  wire [23:0] din,
  output reg  [3:0]  port_dir,
  output wire [1:0]  freq_output,
  output wire [1:0]  freq_drive_en,
  output wire [1:0]  terminal_count
);
  localparam [31:0] TICK_DIV_FULL = `CTD_SYS_HZ / `CTD_TICK_HZ;
  localparam [15:0] TICK_DIV      = TICK_DIV_FULL[15:0];
  // bus phase capture
  reg         wr_pend;
  reg  [5:0]  wr_idx;
  wire        acc    = hsel && hready && htrans[1];
  wire [5:0]  rd_idx = haddr[7:2];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 6'h00;
    end else begin
      wr_pend <= acc && hwrite;
      wr_idx  <= haddr[7:2];
    end
  end
  wire [15:0] wd = hwdata[15:0];
  wire        we_load0  = wr_pend && (wr_idx == `CTD_IDX_LOAD0);
  wire        we_load1  = wr_pend && (wr_idx == `CTD_IDX_LOAD1);
  wire        we_hold0  = wr_pend && (wr_idx == `CTD_IDX_HOLD0);
  wire        we_hold1  = wr_pend && (wr_idx == `CTD_IDX_HOLD1);
  wire        we_cmd0   = wr_pend && (wr_idx == `CTD_IDX_CMD0);
  wire        we_cmd1   = wr_pend && (wr_idx == `CTD_IDX_CMD1);
  wire        we_sel    = wr_pend && (wr_idx == `CTD_IDX_CMDSEL);
  wire        we_irqen  = wr_pend && (wr_idx == `CTD_IDX_IRQEN);
  wire        we_irqclr = wr_pend && (wr_idx == `CTD_IDX_IRQCLR);
  wire        we_dir    = wr_pend && (wr_idx == `CTD_IDX_DIR);
  wire        we_fout0  = wr_pend && (wr_idx == `CTD_IDX_FOUT0);
  wire        we_fout1  = wr_pend && (wr_idx == `CTD_IDX_FOUT1);
  // software registers
  reg  [15:0] reload_word0;
  reg  [15:0] reload_word1;
  reg  [1:0]  counter_select_bits;
  reg  [4:0]  irq_enable_ctrl;
  reg  [15:0] freq_out0_ctrl;
  reg  [15:0] freq_out1_ctrl;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_word0        <= 16'h0000;
      reload_word1        <= 16'h0000;
      counter_select_bits <= 2'h0;
      irq_enable_ctrl     <= `CTD_IRQEN_RST;
      port_dir            <= `CTD_DIR_RST;
      freq_out0_ctrl      <= `CTD_FREQ_OUTPUT_RST;
      freq_out1_ctrl      <= `CTD_FREQ_OUTPUT_RST;
    end else begin
      if (we_load0) reload_word0 <= wd;
      if (we_load1) reload_word1 <= wd;
      if (we_sel) counter_select_bits <= wd[1:0];
      if (we_irqen) irq_enable_ctrl <= wd[4:0];
      if (we_dir) port_dir <= wd[3:0];
      if (we_fout0) freq_out0_ctrl <= wd;
      if (we_fout1) freq_out1_ctrl <= wd;
    end
  end
  // fixed-rate tick chain: 10M, 1M, 100k, 10k, 1k pulses
  reg  [4:0]  cyc;
  reg  [3:0]  dec1;
  reg  [3:0]  dec2;
  reg  [15:0] tick_cnt;
  wire        t10m = cyc[0];
  wire        t1m  = t10m && (cyc == `CTD_CYC_LAST);
  wire        t100k = t1m && (dec1 == `CTD_DEC_LAST);
  wire        t10k = t100k && (dec2 == `CTD_DEC_LAST);
  wire        t1k  = tick_cnt == (TICK_DIV - 16'h0001);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc      <= 5'h00;
      dec1     <= 4'h0;
      dec2     <= 4'h0;
      tick_cnt <= 16'h0000;
    end else begin
      cyc      <= (cyc == `CTD_CYC_LAST) ? 5'h00 : cyc + 5'h01;
      // 1 kHz has its own counter; a third decade would only add ripple depth
      tick_cnt <= t1k ? 16'h0000 : tick_cnt + 16'h0001;
      if (t1m) begin
        dec1 <= (dec1 == `CTD_DEC_LAST) ? 4'h0 : dec1 + 4'h1;
      end
      if (t100k) begin
        dec2 <= (dec2 == `CTD_DEC_LAST) ? 4'h0 : dec2 + 4'h1;
      end
    end
  end
  // counter clock input edges (rising)
  reg  [1:0]  clk_prev;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) clk_prev <= 2'h0;
    else          clk_prev <= clk_in;
  end
  wire [1:0]  clk_edge = clk_in & ~clk_prev;
  // counters
  wire [15:0] count0;
  wire [15:0] count1;
  wire [15:0] snapshot_word0;
  wire [15:0] snapshot_word1;
  wire        armed0;
  wire        armed1;
  wire        cmd0 = (we_cmd0 || we_cmd1) && counter_select_bits[0];
  wire        cmd1 = (we_cmd0 || we_cmd1) && counter_select_bits[1];
  ctd_counter u_cnt0 (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .cmd_stb        (cmd0),
    .opcode_field   (hwdata[2:0]),
    .reload_word    (reload_word0),
    .hold_wr        (we_hold0),
    .hold_wdata     (wd),
    .count_edge     (clk_edge[0]),
    .count          (count0),
    .snapshot_word  (snapshot_word0),
    .armed          (armed0),
    .terminal_count (terminal_count[0])
  );
  ctd_counter u_cnt1 (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .cmd_stb        (cmd1),
    .opcode_field   (hwdata[2:0]),
    .reload_word    (reload_word1),
    .hold_wr        (we_hold1),
    .hold_wdata     (wd),
    .count_edge     (clk_edge[1]),
    .count          (count1),
    .snapshot_word  (snapshot_word1),
    .armed          (armed1),
    .terminal_count (terminal_count[1])
  );
  // frequency outputs; fout1 may chain from fout0
  wire [7:0]  src0 = {t1k, t10k, t100k, t1m, t10m, 1'b0, 1'b0, clk_edge[0]};
  wire [7:0]  src1 = {t1k, t10k, t100k, t1m, t10m, 1'b0, freq_output[0], clk_edge[1]};
  ctd_freq_out u_fo0 (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .ctrl          (freq_out0_ctrl),
    .src_pulses    (src0),
    .freq_output   (freq_output[0]),
    .freq_drive_en (freq_drive_en[0])
  );
  ctd_freq_out u_fo1 (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .ctrl          (freq_out1_ctrl),
    .src_pulses    (src1),
    .freq_output   (freq_output[1]),
    .freq_drive_en (freq_drive_en[1])
  );
  // digital input rising-edge detection; only input-direction groups count
  reg  [23:0] din_prev;
  reg  [23:0] line_flags;
  reg  [1:0]  counter_irq_bits;
  reg         input_irq_group_a;
  reg         input_irq_group_b;
  reg         input_irq_group_c;
  wire [23:0] dir_mask = {{4{port_dir[2]}}, {4{port_dir[0]}}, {8{port_dir[1]}},
                          {8{port_dir[3]}}};
  wire [23:0] din_rise = din & ~din_prev & dir_mask;
  wire [23:0] line_en  = {{8{irq_enable_ctrl[4]}}, {8{irq_enable_ctrl[3]}},
                          {8{irq_enable_ctrl[2]}}};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_prev          <= 24'h000000;
      line_flags        <= 24'h000000;
      counter_irq_bits  <= 2'h0;
      input_irq_group_a <= 1'b0;
      input_irq_group_b <= 1'b0;
      input_irq_group_c <= 1'b0;
    end else begin
      din_prev <= din;
      line_flags <= (we_irqclr ? 24'h000000 : line_flags) | (din_rise & line_en);
      counter_irq_bits <= (we_irqclr ? 2'h0 : counter_irq_bits) |
                          (terminal_count & irq_enable_ctrl[1:0]);
      input_irq_group_a <= (input_irq_group_a && !we_irqclr) ||
                           (|(din_rise[7:0] & line_en[7:0]));
      input_irq_group_b <= (input_irq_group_b && !we_irqclr) ||
                           (|(din_rise[15:8] & line_en[15:8]));
      input_irq_group_c <= (input_irq_group_c && !we_irqclr) ||
                           (|(din_rise[23:16] & line_en[23:16]));
    end
  end
  // read mux, registered into data phase
  reg  [15:0] rd_val;
  always @* begin
    case (rd_idx)
      `CTD_IDX_LOAD0:    rd_val = reload_word0;
      `CTD_IDX_LOAD1:    rd_val = reload_word1;
      `CTD_IDX_HOLD0:    rd_val = snapshot_word0;
      `CTD_IDX_HOLD1:    rd_val = snapshot_word1;
      `CTD_IDX_CMDSEL:   rd_val = {14'h0000, counter_select_bits};
      `CTD_IDX_IRQSTAT:  rd_val = {11'h000, input_irq_group_c, input_irq_group_b,
                                  input_irq_group_a, counter_irq_bits};
      `CTD_IDX_DIR:      rd_val = {12'h000, port_dir};
      `CTD_IDX_PA_FLAGS: rd_val = {8'h00, line_flags[7:0]};
      `CTD_IDX_PB_FLAGS: rd_val = {8'h00, line_flags[15:8]};
      `CTD_IDX_PC_FLAGS: rd_val = {8'h00, line_flags[23:16]};
      `CTD_IDX_FOUT0:    rd_val = freq_out0_ctrl;
      `CTD_IDX_FOUT1:    rd_val = freq_out1_ctrl;
      default:           rd_val = 16'h0000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (acc && !hwrite) hrdata <= {16'h0000, rd_val};
  end
endmodule // ctd_top
`default_nettype wire

// ===== sim/ctd_top_properties.sv
// Purpose: bus and output checks on ctd_top ports
// Assumes: hready is fed back from hreadyout
// Notes:   one clock domain only
`timescale 1ns/1ps
`default_nettype none
`include "ctd_map.vh"
module ctd_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [1:0]  clk_in,
  input wire logic [23:0] din,
  input wire logic [3:0]  port_dir,
  input wire logic [1:0]  freq_output,
  input wire logic [1:0]  freq_drive_en,
  input wire logic [1:0]  terminal_count
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel & hready & htrans[1];
  logic      dp_dir;
  logic      dp_fo0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_dir <= 1'b0;
      dp_fo0 <= 1'b0;
    end else begin
      dp_dir <= take & hwrite & (haddr[7:2] == `CTD_IDX_DIR);
      dp_fo0 <= take & hwrite & (haddr[7:2] == `CTD_IDX_FOUT0);
    end
  end
  // robust to either edge the read data lands on
  sequence s_no_read;
    !(take && !hwrite) ##1 !(take && !hwrite);
  endsequence
  sequence s_dir_wr;
    dp_dir ##1 1'b1;
  endsequence
  sequence s_fo0_wr;
    dp_fo0 ##2 1'b1;
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  AST_RDATA_HOLD: assert property (s_no_read |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_RDATA_UPPER: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_DIR_WRITE: assert property (s_dir_wr |-> port_dir == $past(hwdata[3:0]))
    else $error("direction not taken from write");
  AST_DIR_STABLE: assert property (!dp_dir |=> $stable(port_dir))
    else $error("direction changed without write");
  AST_DRIVE_EN: assert property (s_fo0_wr |-> freq_drive_en[0] == $past(hwdata[12], 2))
    else $error("drive enable not following its bit");
  AST_FREQ_OUTPUT_GATED: assert property ((freq_output & ~freq_drive_en) == 2'b00)
    else $error("frequency pulse while disabled");
  AST_FREQ_OUTPUT_PULSE: assert property (freq_output[0] |=> !freq_output[0])
    else $error("frequency pulse wider than one cycle");
  AST_TC_PULSE: assert property (terminal_count[0] |=> !terminal_count[0])
    else $error("terminal count wider than one cycle");
endmodule // ctd_checker
bind ctd_top ctd_checker u_ctd_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .clk_in(clk_in), .din(din), .port_dir(port_dir),
  .freq_output(freq_output), .freq_drive_en(freq_drive_en), .terminal_count(terminal_count)
);
`default_nettype wire

// ===== sim/ctd_top_tb.sv
// Purpose: register-level test of ctd_top over ahb-lite
// Assumes: zero wait slave, fixed clocks derived from hclk
// Notes:   the 1 khz source dominates run time
`timescale 1ns/1ps
`default_nettype none
`include "ctd_map.vh"
module ctd_top_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  clk_in = 2'h0;
  logic [23:0] din = 24'h0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [3:0]  port_dir;
  wire  [1:0]  freq_output;
  wire  [1:0]  freq_drive_en;
  wire  [1:0]  terminal_count;
  logic [31:0] rd;
  int          num_errors = 0;
  int          total_checks = 0;
  int          tc0 = 0;
  int          tc1 = 0;
  int          f0 = 0;
  int          g;
  int          b;
  int          code[5] = '{3, 4, 5, 6, 7};
  int          per[5] = '{2, 20, 200, 2000, 20000};
  always #25 hclk = ~hclk;
  ctd_top u_ctd_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clk_in(clk_in), .din(din),
    .port_dir(port_dir), .freq_output(freq_output), .freq_drive_en(freq_drive_en),
    .terminal_count(terminal_count)
  );
  always @(posedge hclk) begin
    if (terminal_count[0] === 1'b1) tc0++;
    if (terminal_count[1] === 1'b1) tc1++;
    if (freq_output[0] === 1'b1) f0++;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [15:0] wd);
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0);
    chk(rd, {16'h0, exp});
  endtask
  task automatic cmd(input logic [2:0] op);
    bus(1'b1, `CTD_IDX_CMD0, {13'h0, op});
  endtask
  // edge detect needs only one hclk per level; each level is held 4 hclk
  task automatic edges(input int i, input int k);
    repeat (k) begin
      clk_in[i] <= 1'b1;
      repeat (4) @(posedge hclk);
      clk_in[i] <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask
  task automatic gap(input int i, output int n);
    do @(posedge hclk); while (freq_output[i] !== 1'b1);
    n = 0;
    do begin @(posedge hclk); n++; end while (freq_output[i] !== 1'b1);
  endtask
  function automatic logic [15:0] fo(input logic [2:0] s, input logic [3:0] d);
    return {3'h0, 1'b1, 1'b0, s, 4'h0, d};
  endfunction
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({28'h0, port_dir}, 32'hf);
    rchk(`CTD_IDX_DIR, 16'h000f);
    rchk(`CTD_IDX_IRQSTAT, 16'h0000);
    rchk(6'h3f, 16'h0000);
    bus(1'b1, `CTD_IDX_DIR, 16'h0005);
    rchk(`CTD_IDX_DIR, 16'h0005);
    chk({28'h0, port_dir}, 32'h5);
    bus(1'b1, `CTD_IDX_HOLD0, 16'h1234);
    bus(1'b1, `CTD_IDX_HOLD1, 16'habcd);
    rchk(`CTD_IDX_HOLD0, 16'h1234);
    rchk(`CTD_IDX_HOLD1, 16'habcd);
    $display("test regs done");
    bus(1'b1, `CTD_IDX_CMDSEL, 16'h0001);
    bus(1'b1, `CTD_IDX_IRQEN, 16'h0001);
    bus(1'b1, `CTD_IDX_LOAD0, 16'h0003);
    bus(1'b1, `CTD_IDX_LOAD1, 16'h0002);
    cmd(`CTD_OP_LOAD_ARM);
    edges(0, 2);
    edges(1, 3);
    cmd(`CTD_OP_SAVE);
    rchk(`CTD_IDX_HOLD0, 16'h0001);
    chk(32'(tc1), 32'd0);
    edges(0, 3);
    chk(32'(tc0), 32'd1);
    cmd(`CTD_OP_SAVE);
    rchk(`CTD_IDX_HOLD0, 16'h0003);
    rchk(`CTD_IDX_IRQSTAT, 16'h0001);
    bus(1'b1, `CTD_IDX_IRQCLR, 16'h0000);
    rchk(`CTD_IDX_IRQSTAT, 16'h0000);
    cmd(`CTD_OP_ARM);
    edges(0, 1);
    cmd(`CTD_OP_DISARM_SAVE);
    edges(0, 1);
    rchk(`CTD_IDX_HOLD0, 16'h0002);
    bus(1'b1, `CTD_IDX_LOAD0, 16'h8007);
    cmd(`CTD_OP_LOAD);
    cmd(`CTD_OP_SAVE);
    rchk(`CTD_IDX_HOLD0, 16'h8007);
    cmd(`CTD_OP_ARM);
    edges(0, 1);
    cmd(`CTD_OP_DISARM);
    edges(0, 1);
    cmd(`CTD_OP_SAVE);
    rchk(`CTD_IDX_HOLD0, 16'h8006);
    cmd(`CTD_OP_RESET);
    cmd(`CTD_OP_SAVE);
    rchk(`CTD_IDX_HOLD0, 16'h0000);
    bus(1'b1, `CTD_IDX_CMDSEL, 16'h0002);
    bus(1'b1, `CTD_IDX_CMD1, {13'h0, `CTD_OP_LOAD_ARM});
    edges(1, 2);
    chk(32'(tc1), 32'd1);
    rchk(`CTD_IDX_IRQSTAT, 16'h0000);
    $display("test counters done");
    bus(1'b1, `CTD_IDX_DIR, 16'h000f);
    bus(1'b1, `CTD_IDX_IRQEN, 16'h0004);
    din <= 24'h000208;
    repeat (4) @(posedge hclk);
    rchk(`CTD_IDX_PA_FLAGS, 16'h0008);
    rchk(`CTD_IDX_PB_FLAGS, 16'h0000);
    rchk(`CTD_IDX_IRQSTAT, 16'h0004);
    bus(1'b1, `CTD_IDX_PA_FLAGS, 16'hffff);
    rchk(`CTD_IDX_PA_FLAGS, 16'h0008);
    bus(1'b1, `CTD_IDX_IRQCLR, 16'h5a5a);
    rchk(`CTD_IDX_PA_FLAGS, 16'h0000);
    bus(1'b1, `CTD_IDX_DIR, 16'h0007);
    bus(1'b1, `CTD_IDX_IRQEN, 16'h001c);
    din <= 24'h010609;
    repeat (4) @(posedge hclk);
    rchk(`CTD_IDX_PA_FLAGS, 16'h0000);
    rchk(`CTD_IDX_PB_FLAGS, 16'h0004);
    rchk(`CTD_IDX_PC_FLAGS, 16'h0001);
    rchk(`CTD_IDX_IRQSTAT, 16'h0018);
    $display("test inputs done");
    bus(1'b1, `CTD_IDX_FOUT0, 16'h0300);
    repeat (3) @(posedge hclk);
    chk({31'h0, freq_drive_en[0]}, 32'h0);
    b = f0;
    repeat (20) @(posedge hclk);
    chk(32'(f0 - b), 32'd0);
    bus(1'b1, `CTD_IDX_FOUT0, fo(3'h0, 4'h0));
    b = f0;
    edges(0, 3);
    chk(32'(f0 - b), 32'd3);
    bus(1'b1, `CTD_IDX_FOUT0, fo(3'h3, 4'h1));
    rchk(`CTD_IDX_FOUT0, fo(3'h3, 4'h1));
    chk({31'h0, freq_drive_en[0]}, 32'h1);
    gap(0, g);
    chk(32'(g), 32'd4);
    bus(1'b1, `CTD_IDX_FOUT1, fo(3'h1, 4'h1));
    gap(1, g);
    chk(32'(g), 32'd8);
    chk({31'h0, freq_drive_en[1]}, 32'h1);
    bus(1'b1, `CTD_IDX_FOUT0, fo(3'h3, 4'hf));
    gap(0, g);
    chk(32'(g), 32'd32);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, `CTD_IDX_FOUT0, fo(3'(code[k]), 4'h0));
      gap(0, g);
      chk(32'(g), 32'(per[k]));
    end
    $display("test freq done");
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge hclk);
    num_errors++;
    end_sim();
  end
endmodule // ctd_top_tb
`default_nettype wire
